// >>> src/wct_top.sv
// What this block does
// - Advanced capture needs all higher channels advanced.
// - Two-ramp fault at period end restarts twice.
// - Channel match DMA triggers never fire.
// - First-increment fault escapes blanking window.
// - Dual-slope retrigger leaves the counter alone.
// - Two-ramp end event fires every ramp.
// - Changing the standby bit while enabled stalls bus.
// - Inverted fault input is never filtered.
`timescale 1ns/1ps
`default_nettype none
module wct_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	input  wire logic        fault_i,
	input  wire logic        retrig_i,
	input  wire logic [3:0]  cap_evt_i,
	input  wire logic        standby_i,
	output logic [3:0]       wo_o,
	output logic [3:0]       match_trig_o,
	output logic             ovf_trig_o,
	output logic             end_evt_o,
	output logic             stall_o,
	output logic             irq_o
);
	logic [15:0]         ctrl_reg;
	logic [23:0]         per_reg;
	logic [23:0]         count_reg;
	logic [23:0]         count_next;
	logic [23:0]         cc_reg [4];
	logic [23:0]         cap_val [4];
	logic [11:0]         capmode_reg;
	logic [5:0]          status_reg;
	logic [5:0]          mask_reg;
	logic [5:0]          status_set;
	logic [5:0]          status_clr;
	logic [3:0]          blank_reg;
	logic [3:0]          wo_reg;
	logic [3:0]          cmp;
	logic [3:0]          cap_w;
	logic [3:0]          adv;
	logic [3:0]          adv_ok;
	logic [31:0]         rdata_reg;
	logic                stall_reg;
	logic                hold_reg;
	logic                fprev_reg;
	logic                redo_reg;
	logic                ovf_reg;
	logic                end_reg;
	wct_pkg::wct_state_t state_reg;
	wct_pkg::wct_state_t state_next;
	wct_pkg::wct_wave_t  mode;
	logic                wr_ok;
	logic                rd_ok;
	logic                run;
	logic                top;
	logic                bot;
	logic                up;
	logic                ovf_w;
	logic                end_w;
	logic                fq;
	logic                blanked;
	logic                fact;
	logic                feff;
	logic                dbl_w;
	logic                restart_w;
	logic                stdby_wr;

	// A stalled bus stays dead until reset, as the real part hangs its peripheral bus.
	assign wr_ok = wr_i && !stall_reg;
	assign rd_ok = rd_i && !stall_reg;
	assign mode = wct_pkg::wct_wave_t'(ctrl_reg[wct_pkg::CTRL_WAVE+:2]);
	assign run = ctrl_reg[wct_pkg::CTRL_EN] && !(standby_i && !ctrl_reg[wct_pkg::CTRL_STDBY]);
	assign top = count_reg == per_reg;
	assign bot = count_reg == 24'h00_0000;
	assign up = state_reg != wct_pkg::ST_DOWN;
	assign stdby_wr = wr_ok && (addr_i == wct_pkg::ADDR_CTRL) && ctrl_reg[wct_pkg::CTRL_EN]
		&& (wdata_i[wct_pkg::CTRL_STDBY] != ctrl_reg[wct_pkg::CTRL_STDBY]);

	wct_fault u_fault (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.fault_i   (fault_i),
		.invert_i  (ctrl_reg[wct_pkg::CTRL_FINV]),
		.filt_en_i (ctrl_reg[wct_pkg::CTRL_FFILT]),
		.fault_o   (fq)
	);

	// The blanking window does not cover the very first up-count step.
	assign blanked = ctrl_reg[wct_pkg::CTRL_BLANK] && (blank_reg != 4'h0) && !(up && bot);
	assign fact = fq && !blanked && (!ctrl_reg[wct_pkg::CTRL_QUAL] || wo_reg[0]);
	assign feff = fact || (ctrl_reg[wct_pkg::CTRL_KEEP] && hold_reg);
	assign dbl_w = (mode == wct_pkg::WAVE_TWO_RAMP) && ctrl_reg[wct_pkg::CTRL_KEEP]
		&& ctrl_reg[wct_pkg::CTRL_QUAL] && ctrl_reg[wct_pkg::CTRL_RESTART]
		&& run && fact && !fprev_reg && top;
	assign restart_w = ctrl_reg[wct_pkg::CTRL_RESTART] && run
		&& ((fact && !fprev_reg) || redo_reg);

	always_comb
	begin
		count_next = count_reg;
		state_next = state_reg;
		ovf_w = 1'b0;
		end_w = 1'b0;
		if (run)
		begin
			unique case (state_reg)
				wct_pkg::ST_RAMP_A:
				begin
					if (!top)
						count_next = count_reg + 24'h00_0001;
					else if (mode == wct_pkg::WAVE_DUAL_SLOPE)
					begin
						count_next = count_reg - 24'h00_0001;
						state_next = wct_pkg::ST_DOWN;
					end
					else
					begin
						count_next = 24'h00_0000;
						end_w = 1'b1;
						ovf_w = mode != wct_pkg::WAVE_TWO_RAMP;
						if (mode == wct_pkg::WAVE_TWO_RAMP)
							state_next = wct_pkg::ST_RAMP_B;
					end
				end
				wct_pkg::ST_RAMP_B:
				begin
					if (!top)
						count_next = count_reg + 24'h00_0001;
					else
					begin
						count_next = 24'h00_0000;
						state_next = wct_pkg::ST_RAMP_A;
						ovf_w = 1'b1;
						end_w = 1'b1;
					end
				end
				wct_pkg::ST_DOWN:
				begin
					if (!bot)
						count_next = count_reg - 24'h00_0001;
					else
					begin
						count_next = count_reg + 24'h00_0001;
						state_next = wct_pkg::ST_RAMP_A;
						ovf_w = 1'b1;
						end_w = 1'b1;
					end
				end
				default: state_next = wct_pkg::ST_RAMP_A;
			endcase
			// Dual-slope ignores retrigger events entirely.
			if (restart_w || (retrig_i && (mode != wct_pkg::WAVE_DUAL_SLOPE)))
				count_next = 24'h00_0000;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_reg <= 24'h00_0000;
			state_reg <= wct_pkg::ST_RAMP_A;
			ovf_reg <= 1'b0;
			end_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			state_reg <= state_next;
			ovf_reg <= ovf_w;
			end_reg <= end_w;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			blank_reg <= 4'h0;
			hold_reg <= 1'b0;
			fprev_reg <= 1'b0;
			redo_reg <= 1'b0;
		end
		else
		begin
			if (end_w || restart_w)
				blank_reg <= ctrl_reg[wct_pkg::CTRL_BLEN+:4];
			else if (run && (blank_reg != 4'h0))
				blank_reg <= blank_reg - 4'h1;
			if (fact)
				hold_reg <= 1'b1;
			else if (end_w)
				hold_reg <= 1'b0;
			fprev_reg <= fact;
			redo_reg <= dbl_w;
		end
	end

	genvar i;
	generate
		for (i = 0; i < wct_pkg::NCH; i++)
		begin : g_ch
			assign adv[i] = (capmode_reg[3*i+:3] >= wct_pkg::CAPM_MINIMUM)
				&& (capmode_reg[3*i+:3] <= wct_pkg::CAPM_DERIVATIVE);
			if (i == wct_pkg::NCH - 1)
			begin : g_last
				assign adv_ok[i] = 1'b1;
			end
			else
			begin : g_lower
				assign adv_ok[i] = adv_ok[i+1] && adv[i+1];
			end
			assign cmp[i] = count_reg < cc_reg[i];
			wct_capture u_cap (
				.clk_i    (clk_i),
				.rst_i    (rst_i),
				.mode_i   (capmode_reg[3*i+:3]),
				.adv_ok_i (adv_ok[i]),
				.evt_i    (cap_evt_i[i]),
				.count_i  (count_reg),
				.cc_i     (cc_reg[i]),
				.cap_o    (cap_w[i]),
				.val_o    (cap_val[i])
			);
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					cc_reg[i] <= wct_pkg::CC_RST;
				else if (cap_w[i])
					cc_reg[i] <= cap_val[i];
				else if (wr_ok && (addr_i[7:4] == wct_pkg::ADDR_CC_BANK)
					&& (addr_i[3:2] == 2'(i)) && (addr_i[1:0] == 2'h0))
					cc_reg[i] <= wdata_i[23:0];
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wo_reg <= 4'h0;
		else
			wo_reg <= cmp & {4{!feff}};
	end

	// Only enable and standby stay writable while running; standby is not protected.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_reg <= wct_pkg::CTRL_RST;
		else if (wr_ok && (addr_i == wct_pkg::ADDR_CTRL))
		begin
			if (ctrl_reg[wct_pkg::CTRL_EN])
			begin
				ctrl_reg[wct_pkg::CTRL_EN] <= wdata_i[wct_pkg::CTRL_EN];
				ctrl_reg[wct_pkg::CTRL_STDBY] <= wdata_i[wct_pkg::CTRL_STDBY];
			end
			else
				ctrl_reg <= wdata_i[15:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			stall_reg <= 1'b0;
		else if (stdby_wr)
			stall_reg <= 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			per_reg <= wct_pkg::PER_RST;
			capmode_reg <= wct_pkg::CAPMODE_RST;
			mask_reg <= wct_pkg::MASK_RST;
		end
		else if (wr_ok)
		begin
			if (addr_i == wct_pkg::ADDR_PER)
				per_reg <= wdata_i[23:0];
			if (addr_i == wct_pkg::ADDR_CAPMODE)
				capmode_reg <= wdata_i[11:0];
			if (addr_i == wct_pkg::ADDR_MASK)
				mask_reg <= wdata_i[5:0];
		end
	end

	// A new event in the clearing cycle survives because set is applied last.
	assign status_set = {cap_w, fact && !fprev_reg, ovf_w};
	assign status_clr = (wr_ok && (addr_i == wct_pkg::ADDR_STATUS)) ? wdata_i[5:0] : 6'h00;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_reg <= 6'h00;
		else
			status_reg <= (status_reg & ~status_clr) | status_set;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !rd_ok)
			rdata_reg <= 32'h0000_0000;
		else if ((addr_i[7:4] == wct_pkg::ADDR_CC_BANK) && (addr_i[1:0] == 2'h0))
			rdata_reg <= {8'h00, cc_reg[addr_i[3:2]]};
		else
		begin
			unique case (addr_i)
				wct_pkg::ADDR_CTRL: rdata_reg <= {16'h0000, ctrl_reg};
				wct_pkg::ADDR_PER: rdata_reg <= {8'h00, per_reg};
				wct_pkg::ADDR_COUNT: rdata_reg <= {8'h00, count_reg};
				wct_pkg::ADDR_CAPMODE: rdata_reg <= {20'h0_0000, capmode_reg};
				wct_pkg::ADDR_STATUS: rdata_reg <= {26'h000_0000, status_reg};
				wct_pkg::ADDR_MASK: rdata_reg <= {26'h000_0000, mask_reg};
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	assign rdata_o = rdata_reg;
	assign wo_o = wo_reg;
	assign match_trig_o = 4'h0;
	assign ovf_trig_o = ovf_reg;
	assign end_evt_o = end_reg;
	assign stall_o = stall_reg;
	assign irq_o = |(status_reg & mask_reg);

	chk_double_restart: assert property (@(posedge clk_i) disable iff (rst_i)
		dbl_w |-> restart_w ##1 restart_w) else $error("second restart missing");
	chk_match_dma_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		(cap_w != 4'h0) |-> match_trig_o == 4'h0) else $error("match dma trigger raised");
	chk_first_inc_fault: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl_reg[wct_pkg::CTRL_BLANK] && up && bot && fq && !ctrl_reg[wct_pkg::CTRL_QUAL])
		|-> fact) else $error("first increment fault was blanked");
	chk_dual_retrigger: assert property (@(posedge clk_i) disable iff (rst_i)
		(run && (mode == wct_pkg::WAVE_DUAL_SLOPE) && retrig_i && !top && !restart_w
		&& (state_reg == wct_pkg::ST_RAMP_A)) |=> count_reg == $past(count_reg) + 24'h00_0001)
		else $error("dual slope retrigger moved counter");
	chk_ramp_end_event: assert property (@(posedge clk_i) disable iff (rst_i)
		(run && (mode == wct_pkg::WAVE_TWO_RAMP) && (state_reg == wct_pkg::ST_RAMP_A) && top)
		|=> end_evt_o && !ovf_trig_o && (state_reg == wct_pkg::ST_RAMP_B))
		else $error("first ramp end event wrong");
	chk_standby_stall: assert property (@(posedge clk_i) disable iff (rst_i)
		stdby_wr |=> stall_o && (ctrl_reg[wct_pkg::CTRL_STDBY] == $past(wdata_i[1])))
		else $error("standby write did not stall");
	chk_stall_dead_bus: assert property (@(posedge clk_i) disable iff (rst_i)
		(stall_o && rd_i) |=> (rdata_o == 32'h0000_0000) && stall_o)
		else $error("stalled bus answered");
	chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		(ovf_w && mask_reg[wct_pkg::ST_OVF]) |=> irq_o) else $error("overflow interrupt missing");
endmodule
`default_nettype wire

// >>> inc/wct_pkg.sv
package wct_pkg;
	localparam int CW = 24;
	localparam int NCH = 4;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int CAPM_W = 3;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PER = 8'h04;
	localparam logic [7:0] ADDR_COUNT = 8'h08;
	localparam logic [7:0] ADDR_CAPMODE = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;
	localparam logic [3:0] ADDR_CC_BANK = 4'h2;
	localparam int CTRL_EN = 0;
	localparam int CTRL_STDBY = 1;
	localparam int CTRL_WAVE = 2;
	localparam int CTRL_FINV = 4;
	localparam int CTRL_FFILT = 5;
	localparam int CTRL_BLANK = 6;
	localparam int CTRL_KEEP = 7;
	localparam int CTRL_QUAL = 8;
	localparam int CTRL_RESTART = 9;
	localparam int CTRL_BLEN = 12;
	localparam int CTRL_W = 16;
	localparam int ST_OVF = 0;
	localparam int ST_FAULT = 1;
	localparam int ST_CAP0 = 2;
	localparam int ST_W = 6;
	localparam int FILT_LEN = 3;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [23:0] PER_RST = 24'hFF_FFFF;
	localparam logic [23:0] CC_RST = 24'h00_0000;
	localparam logic [11:0] CAPMODE_RST = 12'h000;
	localparam logic [5:0] MASK_RST = 6'h00;
	typedef enum logic [1:0] {
		WAVE_NORMAL = 2'h0,
		WAVE_DUAL_SLOPE = 2'h1,
		WAVE_TWO_RAMP = 2'h2
	} wct_wave_t;
	typedef enum logic [2:0] {
		CAPM_COMPARE = 3'h0,
		CAPM_BASIC = 3'h1,
		CAPM_MINIMUM = 3'h2,
		CAPM_MAXIMUM = 3'h3,
		CAPM_LOCAL_MIN = 3'h4,
		CAPM_LOCAL_MAX = 3'h5,
		CAPM_DERIVATIVE = 3'h6
	} wct_capm_t;
	typedef enum logic [1:0] {
		ST_RAMP_A = 2'h0,
		ST_RAMP_B = 2'h1,
		ST_DOWN = 2'h2
	} wct_state_t;
endpackage

// >>> src/wct_capture.sv
`timescale 1ns/1ps
`default_nettype none
module wct_capture (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [2:0]  mode_i,
	input  wire logic        adv_ok_i,
	input  wire logic        evt_i,
	input  wire logic [23:0] count_i,
	input  wire logic [23:0] cc_i,
	output logic             cap_o,
	output logic [23:0]      val_o
);
	logic take;
	logic adv;

	assign adv = (mode_i >= wct_pkg::CAPM_MINIMUM) && (mode_i <= wct_pkg::CAPM_DERIVATIVE);

	always_comb
	begin
		take = 1'b0;
		case (mode_i)
			wct_pkg::CAPM_BASIC: take = evt_i;
			wct_pkg::CAPM_MINIMUM, wct_pkg::CAPM_LOCAL_MIN: take = evt_i && (count_i < cc_i);
			wct_pkg::CAPM_MAXIMUM, wct_pkg::CAPM_LOCAL_MAX: take = evt_i && (count_i > cc_i);
			wct_pkg::CAPM_DERIVATIVE: take = evt_i;
			default: take = 1'b0;
		endcase
		// An advanced mode is dead unless every higher channel is advanced too.
		if (adv && !adv_ok_i)
			take = 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cap_o <= 1'b0;
			val_o <= wct_pkg::CC_RST;
		end
		else
		begin
			cap_o <= take;
			if (take)
				val_o <= count_i;
		end
	end

	chk_adv_mode_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		(evt_i && adv && !adv_ok_i) |=> !cap_o) else $error("advanced capture taken without support");
endmodule
`default_nettype wire

// >>> src/wct_fault.sv
`timescale 1ns/1ps
`default_nettype none
module wct_fault (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic fault_i,
	input  wire logic invert_i,
	input  wire logic filt_en_i,
	output logic      fault_o
);
	logic [wct_pkg::FILT_LEN-1:0] hist_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			hist_reg <= '0;
		else
			hist_reg <= {hist_reg[wct_pkg::FILT_LEN-2:0], fault_i};
	end

	// The filter only ever sees the raw polarity, so an inverted input passes unfiltered.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fault_o <= 1'b0;
		else if (invert_i)
			fault_o <= ~fault_i;
		else if (!filt_en_i)
			fault_o <= fault_i;
		else if (&hist_reg)
			fault_o <= 1'b1;
		else if (~|hist_reg)
			fault_o <= 1'b0;
	end

	chk_invert_unfiltered: assert property (@(posedge clk_i) disable iff (rst_i)
		invert_i |=> fault_o == !$past(fault_i)) else $error("inverted fault not passed raw");
	chk_filter_glitch: assert property (@(posedge clk_i) disable iff (rst_i)
		(!invert_i && filt_en_i && !fault_o && !hist_reg[0]) |=> !fault_o)
		else $error("filtered fault rose too early");
endmodule
`default_nettype wire

// >>> tb/wct_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: fault line, capture events and retrigger, launched after each edge.
module wct_far_model (
	input  wire logic       clk_i,
	input  wire logic       act_i,
	input  wire logic       inv_i,
	input  wire logic       retrig_i,
	input  wire logic [3:0] cap_i,
	output logic            fault_o,
	output logic            retrig_o,
	output logic [3:0]      cap_o
);
	initial
	begin
		fault_o = 1'b0;
		retrig_o = 1'b0;
		cap_o = 4'h0;
	end
	// An inverted line idles high, so an active fault pulls it low.
	always @(posedge clk_i)
	begin
		fault_o <= act_i ^ inv_i;
		retrig_o <= retrig_i;
		cap_o <= cap_i;
	end
endmodule
`default_nettype wire

// >>> tb/wct_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wct_top_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        standby_i = 1'b0;
	logic        act = 1'b0;
	logic        inv = 1'b0;
	logic        rtg = 1'b0;
	logic [3:0]  cap = 4'h0;
	logic        fault_i;
	logic        retrig_i;
	logic [3:0]  cap_evt_i;
	logic [31:0] rdata_o;
	logic [3:0]  wo_o;
	logic [3:0]  match_trig_o;
	logic        ovf_trig_o;
	logic        end_evt_o;
	logic        stall_o;
	logic        irq_o;
	logic        rd_d = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] v;
	int          fail_count = 0;
	int          checked = 0;
	int          seed = 30444;
	int          ovf_n;
	int          end_n;
	int          mt_n;
	always #4 clk_i = ~clk_i;
	wct_far_model far (.clk_i(clk_i), .act_i(act), .inv_i(inv), .retrig_i(rtg),
		.cap_i(cap), .fault_o(fault_i), .retrig_o(retrig_i), .cap_o(cap_evt_i));
	wct_top dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fault_i(fault_i),
		.retrig_i(retrig_i), .cap_evt_i(cap_evt_i), .standby_i(standby_i),
		.wo_o(wo_o), .match_trig_o(match_trig_o), .ovf_trig_o(ovf_trig_o),
		.end_evt_o(end_evt_o), .stall_o(stall_o), .irq_o(irq_o));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken there.
	always @(posedge clk_i)
	begin
		if (rd_d && exp_q.size() > 0)
			chk(rdata_o, exp_q.pop_front());
		rd_d <= rd_i;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		rd_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge clk_i);
		addr_i <= a;
		wr_i <= 1'b0;
		rd_i <= 1'b1;
	endtask
	task automatic idle(input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			wr_i <= 1'b0;
			rd_i <= 1'b0;
		end
	endtask
	task automatic fpulse();
		idle(1);
		act <= 1'b1;
		idle(1);
		act <= 1'b0;
	endtask
	task automatic cnt(input int n);
		ovf_n = 0;
		end_n = 0;
		mt_n = 0;
		repeat (n)
		begin
			@(posedge clk_i);
			#1;
			if (ovf_trig_o === 1'b1)
				ovf_n++;
			if (end_evt_o === 1'b1)
				end_n++;
			if (match_trig_o !== 4'h0)
				mt_n++;
		end
	endtask
	// Windows start on an overflow pulse so that whole periods are counted.
	task automatic sync_ovf();
		int k;
		k = 0;
		idle(1);
		#1;
		while (k < 40 && ovf_trig_o !== 1'b1)
		begin
			@(posedge clk_i);
			#1;
			k++;
		end
	endtask
	task automatic sync_end();
		int k;
		k = 0;
		idle(1);
		#1;
		while (k < 40 && end_evt_o !== 1'b1)
		begin
			@(posedge clk_i);
			#1;
			k++;
		end
	endtask
	task automatic wrap_up();
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#100000;
		fail_count++;
		wrap_up();
	end
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(wct_pkg::ADDR_PER, {8'h00, wct_pkg::PER_RST});
		rd(wct_pkg::ADDR_CTRL, {16'h0000, wct_pkg::CTRL_RST});
		rd(8'h30, 32'h0000_0000);
		wr(wct_pkg::ADDR_COUNT, 32'h0000_0055);
		rd(wct_pkg::ADDR_COUNT, 32'h0000_0000);
		for (int i = 0; i < 4; i++)
		begin
			v = $random(seed) & 32'h00FF_FFFF;
			wr(wct_pkg::ADDR_PER, v);
			rd(wct_pkg::ADDR_PER, v);
			wr({wct_pkg::ADDR_CC_BANK, i[1:0], 2'b00}, v ^ 32'h00A5_5A5A);
			rd({wct_pkg::ADDR_CC_BANK, i[1:0], 2'b00}, v ^ 32'h00A5_5A5A);
		end
		// Derivative on the lower channels under basic upper ones must stay silent.
		wr(wct_pkg::ADDR_CAPMODE, 32'h0000_0276);
		wr(wct_pkg::ADDR_STATUS, 32'h0000_003F);
		idle(1);
		cap <= 4'hF;
		idle(1);
		cap <= 4'h0;
		idle(3);
		rd(wct_pkg::ADDR_STATUS, 32'h0000_0030);
		wr(wct_pkg::ADDR_CAPMODE, 32'h0000_0D89);
		wr(wct_pkg::ADDR_STATUS, 32'h0000_003F);
		idle(1);
		cap <= 4'hF;
		idle(1);
		cap <= 4'h0;
		idle(3);
		rd(wct_pkg::ADDR_STATUS, 32'h0000_003C);
		wr(wct_pkg::ADDR_MASK, 32'h0000_003C);
		idle(2);
		chk(irq_o, 1'b1);
		wr(wct_pkg::ADDR_STATUS, 32'h0000_003C);
		idle(2);
		chk(irq_o, 1'b0);
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0020);
		idle(4);
		wr(wct_pkg::ADDR_STATUS, 32'h0000_003F);
		fpulse();
		idle(6);
		rd(wct_pkg::ADDR_STATUS, 32'h0000_0000);
		act <= 1'b1;
		idle(6);
		rd(wct_pkg::ADDR_STATUS, 32'h0000_0002);
		inv <= 1'b1;
		act <= 1'b0;
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0030);
		idle(6);
		wr(wct_pkg::ADDR_STATUS, 32'h0000_003F);
		fpulse();
		idle(6);
		rd(wct_pkg::ADDR_STATUS, 32'h0000_0002);
		inv <= 1'b0;
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0000);
		wr(wct_pkg::ADDR_PER, 32'h0000_0002);
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0001);
		sync_ovf();
		cnt(30);
		chk(ovf_n, 32'h0000_000A);
		chk(end_n, 32'h0000_000A);
		chk(mt_n, 32'h0000_0000);
		rtg <= 1'b1;
		idle(3);
		cnt(20);
		chk(ovf_n, 32'h0000_0000);
		rtg <= 1'b0;
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0000);
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0009);
		sync_ovf();
		cnt(30);
		chk(ovf_n, 32'h0000_0005);
		chk(end_n, 32'h0000_000A);
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0000);
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0005);
		rtg <= 1'b1;
		idle(3);
		cnt(20);
		chk(ovf_n != 0, 1'b1);
		chk(mt_n, 32'h0000_0000);
		rtg <= 1'b0;
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0003);
		idle(2);
		chk(stall_o, 1'b1);
		rd(wct_pkg::ADDR_PER, 32'h0000_0000);
		idle(3);
		rst_i <= 1'b1;
		idle(2);
		rst_i <= 1'b0;
		idle(1);
		chk(stall_o, 1'b0);
		rd(wct_pkg::ADDR_CTRL, 32'h0000_0000);
		wr({wct_pkg::ADDR_CC_BANK, 4'h0}, 32'h0000_0001);
		wr(wct_pkg::ADDR_PER, 32'h0000_0002);
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0001);
		sync_ovf();
		chk(wo_o, 4'h0);
		idle(1);
		#1;
		chk(wo_o, 4'h1);
		// Standby without run-in-standby must freeze the counter at its top value.
		idle(1);
		standby_i <= 1'b1;
		rd(wct_pkg::ADDR_COUNT, 32'h0000_0002);
		standby_i <= 1'b0;
		wr(wct_pkg::ADDR_MASK, 32'h0000_0001);
		idle(4);
		chk(irq_o, 1'b1);
		// The window outlasts the period, so only the count-zero step lets a fault in.
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0000);
		wr(wct_pkg::ADDR_CTRL, 32'h0000_F041);
		idle(6);
		wr(wct_pkg::ADDR_STATUS, 32'h0000_003F);
		act <= 1'b1;
		idle(8);
		rd(wct_pkg::ADDR_STATUS, 32'h0000_0003);
		act <= 1'b0;
		// A qualified fault landing on a ramp top restarts twice, so the next end is late.
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0000);
		wr(wct_pkg::ADDR_PER, 32'h0000_0003);
		wr({wct_pkg::ADDR_CC_BANK, 4'h0}, 32'h0000_0003);
		wr(wct_pkg::ADDR_CTRL, 32'h0000_0389);
		sync_end();
		idle(1);
		act <= 1'b1;
		cnt(7);
		chk(end_n, 32'h0000_0001);
		act <= 1'b0;
		idle(4);
		wrap_up();
	end
endmodule
`default_nettype wire
